// ---- cpf_protect_fsm.sv ----
// Operation
// - No fault keeps both switches on.
// - Qualified overcharge turns charge switch off.
// - Below overcharge release returns to normal.
// - Load event releases overcharge once cell allows.
// - Terminal below overcurrent level blocks release.
// - Overcharge suppresses overcurrent; short always active.
// - Qualified overdischarge turns discharge switch off.
// - Overdischarge pulls up; high terminal powers down.
// - Charger wake leaves power-down, discharge off.
// - Charger and release level return to normal.
// - Qualified overcurrent turns discharge switch off.
// - Overcurrent enables terminal pull-down resistor.
// - Terminal below overcurrent level returns normal.
// - Qualified low terminal is abnormal charge fault.
// - Overdischarge abnormal charge waits for detect level.
// - Charger removal clears abnormal charge fault.
// - Zero-volt charging outranks abnormal charge detection.
// - Load short trips; releases when terminal drops.
// - Short timer starts with overcurrent detection.
// - Overdischarge during overcurrent leads to power-down.
// - Zero-volt cell charges, discharge off, then normal.
// - Overcharge delay 128 ms, at most 200.
// - Overdischarge delay 32 ms, at most 60.
// - Overcurrent delay 8 ms.
// - Load short delay 100 us.
`timescale 1ns/10ps
module cpf_protect_fsm #(
  parameter int unsigned OVCHG_CYCLES = cpf_pkg::OVCHG_CYCLES,
  parameter int unsigned ODSG_CYCLES  = cpf_pkg::ODSG_CYCLES,
  parameter int unsigned OCUR_CYCLES  = cpf_pkg::OCUR_CYCLES,
  parameter int unsigned SHORT_CYCLES = cpf_pkg::SHORT_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire cpf_pkg::cpf_flags_t flags_i,
  output cpf_pkg::cpf_drive_t      drive_q,
  output cpf_pkg::cpf_state_t      state_q
);

  if (OVCHG_CYCLES > cpf_pkg::OVCHG_MAX_CYCLES || ODSG_CYCLES > cpf_pkg::ODSG_MAX_CYCLES) begin : g_bad_delay
    $error("qualification delay beyond its documented maximum");
  end

  cpf_pkg::cpf_flags_t flags_q;
  cpf_pkg::cpf_state_t state_d;
  cpf_pkg::cpf_drive_t drive_d;
  logic                load_pend_q;
  logic                load_pend_d;

  cpf_flag_reg u_flags (
    .clk     (clk),
    .rst_n   (rst_n),
    .flags_i (flags_i),
    .flags_q (flags_q)
  );

  // State membership shorthands.
  wire in_normal = (state_q == cpf_pkg::ST_NORMAL);
  wire in_ovchg  = (state_q == cpf_pkg::ST_OVCHG);
  wire in_odsg   = (state_q == cpf_pkg::ST_ODSG);
  wire in_pwrdn  = (state_q == cpf_pkg::ST_PWRDN);
  wire in_ocur   = (state_q == cpf_pkg::ST_OCUR);
  wire in_short  = (state_q == cpf_pkg::ST_SHORT);
  wire in_zero   = (state_q == cpf_pkg::ST_ZERO);
  wire in_abnchg = (state_q == cpf_pkg::ST_ABNCHG);

  // Timer conditions; each is gated by the states in which it may act.
  wire ovchg_cond = flags_q.cell_above_overcharge_detect && in_normal;
  wire odsg_cond  = flags_q.cell_below_overdischarge_detect && (in_normal || in_ocur);
  wire ocur_cond  = flags_q.term_at_overcurrent && !flags_q.cell_above_overcharge_detect
                    && in_normal;
  wire oc1_seen   = flags_q.term_at_overcurrent && (in_normal || in_ovchg || in_abnchg);
  wire abn_cond   = flags_q.term_below_charger_detect && !flags_q.cell_below_overdischarge_detect
                    && (in_normal || in_odsg);

  wire ovchg_exp;
  wire odsg_exp;
  wire ocur_exp;
  wire short_exp;
  wire abn_exp;

  cpf_qual_timer #(.COUNT(OVCHG_CYCLES)) u_ovchg_tmr (
    .clk     (clk),
    .rst_n   (rst_n),
    .cond    (ovchg_cond),
    .expired (ovchg_exp)
  );

  cpf_qual_timer #(.COUNT(ODSG_CYCLES)) u_odsg_tmr (
    .clk     (clk),
    .rst_n   (rst_n),
    .cond    (odsg_cond),
    .expired (odsg_exp)
  );

  cpf_qual_timer #(.COUNT(OCUR_CYCLES)) u_ocur_tmr (
    .clk     (clk),
    .rst_n   (rst_n),
    .cond    (ocur_cond),
    .expired (ocur_exp)
  );

  cpf_qual_timer #(.COUNT(SHORT_CYCLES)) u_short_tmr (
    .clk     (clk),
    .rst_n   (rst_n),
    .cond    (oc1_seen),
    .expired (short_exp)
  );

  // The abnormal charge delay shares the overcharge figure but runs on its own counter.
  cpf_qual_timer #(.COUNT(OVCHG_CYCLES)) u_abn_tmr (
    .clk     (clk),
    .rst_n   (rst_n),
    .cond    (abn_cond),
    .expired (abn_exp)
  );

  // Short trips whatever the cell voltage once its delay from overcurrent detection has run.
  wire short_trip = short_exp && flags_q.term_at_load_short;

  // A load event in overcharge is remembered until the cell lets it release.
  wire load_event   = flags_q.term_above_diode_drop && flags_q.term_at_overcurrent;
  assign load_pend_d = in_ovchg && (load_pend_q || load_event);
  wire load_release = load_pend_d && !flags_q.cell_above_overcharge_detect;

  // Charger presence in overdischarge is a terminal pulled below the charger level.
  wire charger_on = flags_q.term_below_charger_detect;

  // Next-state selection with protective transitions ahead of releases, except in ST_ODSG where the release is checked first.
  always_comb begin
    state_d = state_q;
    case (state_q)
      cpf_pkg::ST_NORMAL: begin
        if (short_trip) begin
          state_d = cpf_pkg::ST_SHORT;
        end else if (ocur_exp) begin
          state_d = cpf_pkg::ST_OCUR;
        end else if (odsg_exp) begin
          state_d = cpf_pkg::ST_ODSG;
        end else if (ovchg_exp) begin
          state_d = cpf_pkg::ST_OVCHG;
        end else if (abn_exp) begin
          state_d = cpf_pkg::ST_ABNCHG;
        end
      end
      cpf_pkg::ST_OVCHG: begin
        if (short_trip) begin
          state_d = cpf_pkg::ST_SHORT;
        end else if (flags_q.cell_below_overcharge_release || load_release) begin
          state_d = cpf_pkg::ST_NORMAL;
        end
      end
      cpf_pkg::ST_ODSG: begin
        if (charger_on && flags_q.cell_at_overdischarge_release) begin
          state_d = cpf_pkg::ST_NORMAL;
        end else if (abn_exp) begin
          state_d = cpf_pkg::ST_ABNCHG;
        end else if (flags_q.term_above_powerdown) begin
          state_d = cpf_pkg::ST_PWRDN;
        end
      end
      cpf_pkg::ST_PWRDN: begin
        if (flags_q.charger_at_zero_volt_start) begin
          state_d = cpf_pkg::ST_ZERO;
        end else if (flags_q.supply_term_diff_wake) begin
          state_d = cpf_pkg::ST_ODSG;
        end
      end
      cpf_pkg::ST_OCUR: begin
        if (odsg_exp) begin
          state_d = cpf_pkg::ST_PWRDN;
        end else if (!flags_q.term_at_overcurrent) begin
          state_d = cpf_pkg::ST_NORMAL;
        end
      end
      cpf_pkg::ST_SHORT: begin
        if (!flags_q.term_at_load_short) begin
          state_d = cpf_pkg::ST_NORMAL;
        end
      end
      cpf_pkg::ST_ZERO: begin
        if (flags_q.cell_at_overdischarge_release) begin
          state_d = cpf_pkg::ST_NORMAL;
        end
      end
      cpf_pkg::ST_ABNCHG: begin
        if (short_trip) begin
          state_d = cpf_pkg::ST_SHORT;
        end else if (!flags_q.term_below_charger_detect) begin
          state_d = cpf_pkg::ST_NORMAL;
        end
      end
      default: state_d = cpf_pkg::RESET_STATE;
    endcase
  end

  // Enables are decoded from the next state so they stay aligned with state_q.
  assign drive_d = cpf_pkg::cpf_decode(state_d);

  // State, pending load event and registered enables.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q     <= cpf_pkg::RESET_STATE;
      drive_q     <= cpf_pkg::cpf_decode(cpf_pkg::RESET_STATE);
      load_pend_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      drive_q     <= drive_d;
      load_pend_q <= load_pend_d;
    end
  end

  // Checks on the protection behaviour.
  a_normal_both_on: assert property (@(posedge clk) disable iff (!rst_n)
    in_normal |-> drive_q.chg_en && drive_q.dsg_en && !drive_q.powerdown)
    else $error("normal state without both switches on");

  a_ovchg_entry: assert property (@(posedge clk) disable iff (!rst_n)
    in_normal && ovchg_exp && !short_trip && !ocur_exp && !odsg_exp
    |=> in_ovchg && !drive_q.chg_en)
    else $error("qualified overcharge did not stop charging");

  a_ovchg_release: assert property (@(posedge clk) disable iff (!rst_n)
    in_ovchg && !short_trip && flags_q.cell_below_overcharge_release |=> in_normal && drive_q.chg_en)
    else $error("overcharge not released below release level");

  a_load_hold: assert property (@(posedge clk) disable iff (!rst_n)
    in_ovchg && !short_trip && !flags_q.cell_below_overcharge_release
    && flags_q.cell_above_overcharge_detect |=> in_ovchg || in_short)
    else $error("overcharge left while cell above detect level");

  a_oc_suppress: assert property (@(posedge clk) disable iff (!rst_n)
    in_normal && flags_q.cell_above_overcharge_detect |=> !in_ocur)
    else $error("overcurrent acted while cell above overcharge level");

  a_odsg_entry: assert property (@(posedge clk) disable iff (!rst_n)
    in_normal && odsg_exp && !short_trip && !ocur_exp |=> in_odsg && !drive_q.dsg_en && drive_q.pullup_en)
    else $error("qualified overdischarge did not stop discharging");

  a_pullup_held: assert property (@(posedge clk) disable iff (!rst_n)
    (in_odsg || in_pwrdn) |-> drive_q.pullup_en && !drive_q.dsg_en)
    else $error("pull-up missing in overdischarge or power-down");

  a_wake_from_pd: assert property (@(posedge clk) disable iff (!rst_n)
    in_pwrdn && flags_q.supply_term_diff_wake && !flags_q.charger_at_zero_volt_start
    |=> in_odsg && !drive_q.powerdown && !drive_q.dsg_en)
    else $error("charger did not wake from power-down");

  a_ocur_pulldown: assert property (@(posedge clk) disable iff (!rst_n)
    in_ocur |-> drive_q.pulldown_en && !drive_q.dsg_en)
    else $error("pull-down missing in overcurrent");

  a_ocur_exit: assert property (@(posedge clk) disable iff (!rst_n)
    in_ocur && !odsg_exp && !flags_q.term_at_overcurrent |=> in_normal && drive_q.dsg_en && !drive_q.pulldown_en)
    else $error("overcurrent not released below detect level");

  a_short_trip: assert property (@(posedge clk) disable iff (!rst_n)
    in_normal && short_trip |=> in_short && !drive_q.dsg_en)
    else $error("load short did not stop discharging");

  a_chg_fall_cause: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(drive_q.chg_en) |-> $past(ovchg_exp) || $past(abn_exp) || in_zero)
    else $error("charge switch fell without qualified cause");

  a_pwrdn_entry: assert property (@(posedge clk) disable iff (!rst_n)
    in_odsg && !charger_on && !abn_exp && flags_q.term_above_powerdown
    |=> in_pwrdn && drive_q.powerdown && drive_q.pullup_en)
    else $error("high terminal in overdischarge did not power down");

  a_odsg_release: assert property (@(posedge clk) disable iff (!rst_n)
    in_odsg && charger_on && flags_q.cell_at_overdischarge_release |=> in_normal && drive_q.dsg_en)
    else $error("charger at release level did not end overdischarge");

  a_abn_entry: assert property (@(posedge clk) disable iff (!rst_n)
    in_normal && abn_exp && !short_trip && !ocur_exp && !odsg_exp && !ovchg_exp
    |=> in_abnchg && !drive_q.chg_en && drive_q.dsg_en)
    else $error("qualified abnormal charge did not stop charging");

  a_abn_release: assert property (@(posedge clk) disable iff (!rst_n)
    in_abnchg && !short_trip && !flags_q.term_below_charger_detect |=> in_normal && drive_q.chg_en)
    else $error("abnormal charge fault not cleared on charger removal");

  a_abn_zero_prio: assert property (@(posedge clk) disable iff (!rst_n)
    (in_normal || in_odsg) && flags_q.cell_below_overdischarge_detect |=> !in_abnchg)
    else $error("abnormal charge acted while cell below overdischarge level");

  a_zero_charge: assert property (@(posedge clk) disable iff (!rst_n)
    in_zero |-> drive_q.chg_gate_supply && !drive_q.dsg_en && !drive_q.chg_en)
    else $error("zero-volt charging without gate tie or with discharge on");

  a_ocur_to_pd: assert property (@(posedge clk) disable iff (!rst_n)
    in_ocur && odsg_exp |=> in_pwrdn && drive_q.powerdown)
    else $error("overdischarge during overcurrent did not power down");

  a_short_release: assert property (@(posedge clk) disable iff (!rst_n)
    in_short && !flags_q.term_at_load_short |=> in_normal && drive_q.dsg_en)
    else $error("load short not released when terminal dropped");

  c_overcharge: cover property (@(posedge clk) disable iff (!rst_n) in_ovchg ##1 in_normal);
  c_powerdown_wake: cover property (@(posedge clk) disable iff (!rst_n) in_pwrdn ##1 in_odsg);
  c_short: cover property (@(posedge clk) disable iff (!rst_n) in_short);
  c_abn_charge: cover property (@(posedge clk) disable iff (!rst_n) in_abnchg ##1 in_normal);
  c_zero_volt: cover property (@(posedge clk) disable iff (!rst_n) in_zero ##1 in_normal);

endmodule : cpf_protect_fsm

// ---- cpf_pkg.sv ----
package cpf_pkg;

  // Clock and qualification delay figures, each in its own unit.
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned NS_PER_MS        = 1000000;
  localparam int unsigned NS_PER_US        = 1000;
  localparam int unsigned OVCHG_DELAY_MS   = 128;
  localparam int unsigned OVCHG_DELAY_MAX  = 200;
  localparam int unsigned ODSG_DELAY_MS    = 32;
  localparam int unsigned ODSG_DELAY_MAX   = 60;
  localparam int unsigned OCUR_DELAY_MS    = 8;
  localparam int unsigned SHORT_DELAY_US   = 100;

  // Cycle counts; all figures divide exactly, so least times need no rounding.
  localparam int unsigned OVCHG_CYCLES     = (OVCHG_DELAY_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned OVCHG_MAX_CYCLES = (OVCHG_DELAY_MAX * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned ODSG_CYCLES      = (ODSG_DELAY_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned ODSG_MAX_CYCLES  = (ODSG_DELAY_MAX * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned OCUR_CYCLES      = (OCUR_DELAY_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned SHORT_CYCLES     = (SHORT_DELAY_US * NS_PER_US) / CLK_PERIOD_NS;

  // Comparator flags, each high while its condition holds.
  typedef struct packed {
    logic cell_above_overcharge_detect;    // Cell above overcharge_detect_level.
    logic cell_below_overcharge_release;   // Cell below overcharge_release_level.
    logic cell_below_overdischarge_detect; // Cell below overdischarge_detect_level.
    logic cell_at_overdischarge_release;   // Cell at or above overdischarge_release_level.
    logic term_above_diode_drop;           // Terminal about one diode drop above ground.
    logic term_at_overcurrent;             // Terminal at or above overcurrent_detect_level.
    logic term_at_load_short;              // Terminal at or above load_short_level.
    logic term_below_charger_detect;       // Terminal below charger_detect_level.
    logic term_above_powerdown;            // Terminal above the power-down level.
    logic supply_term_diff_wake;           // Supply minus terminal at the wake level or more.
    logic charger_at_zero_volt_start;      // Charger at zero_volt_charge_start_level or more.
  } cpf_flags_t;

  localparam int unsigned FLAG_W = $bits(cpf_flags_t);

  // Switch and resistor enables driven towards the analog side.
  typedef struct packed {
    logic chg_en;          // Charge-control switch on.
    logic dsg_en;          // Discharge-control switch on.
    logic pullup_en;       // terminal_pullup_resistor enabled.
    logic pulldown_en;     // terminal_pulldown_resistor enabled.
    logic powerdown;       // Draw only powerdown_current.
    logic chg_gate_supply; // Charge-switch gate tied to supply.
  } cpf_drive_t;

  // Protection states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_NORMAL = 3'h0,
    ST_OVCHG  = 3'h1,
    ST_ODSG   = 3'h3,
    ST_PWRDN  = 3'h2,
    ST_OCUR   = 3'h6,
    ST_SHORT  = 3'h7,
    ST_ZERO   = 3'h5,
    ST_ABNCHG = 3'h4
  } cpf_state_t;

  localparam cpf_state_t RESET_STATE = ST_NORMAL;

  // Maps a state onto the enables it drives.
  function automatic cpf_drive_t cpf_decode(input cpf_state_t st);
    cpf_drive_t d;
    d = '{chg_en: 1'b1, dsg_en: 1'b1, pullup_en: 1'b0, pulldown_en: 1'b0,
          powerdown: 1'b0, chg_gate_supply: 1'b0};
    case (st)
      ST_NORMAL: d = d;
      ST_OVCHG,
      ST_ABNCHG: d.chg_en = 1'b0;
      ST_ODSG: begin
        d.dsg_en    = 1'b0;
        d.pullup_en = 1'b1;
      end
      ST_PWRDN: begin
        d.dsg_en    = 1'b0;
        d.pullup_en = 1'b1;
        d.powerdown = 1'b1;
      end
      ST_OCUR,
      ST_SHORT: begin
        d.dsg_en      = 1'b0;
        d.pulldown_en = 1'b1;
      end
      ST_ZERO: begin
        d.chg_en          = 1'b0;
        d.dsg_en          = 1'b0;
        d.chg_gate_supply = 1'b1;
      end
      default: d = d;
    endcase
    return d;
  endfunction : cpf_decode

endpackage : cpf_pkg

// ---- cpf_flag_reg.sv ----
`timescale 1ns/10ps
module cpf_flag_reg (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire cpf_pkg::cpf_flags_t flags_i,
  output cpf_pkg::cpf_flags_t      flags_q
);

  // Comparator flags are registered once before the state machine reads them.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_i;
    end
  end

  a_flag_capture: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> flags_q == $past(flags_i))
    else $error("flag register did not capture its inputs");

endmodule : cpf_flag_reg

// ---- cpf_qual_timer.sv ----
`timescale 1ns/10ps
module cpf_qual_timer #(
  parameter int unsigned COUNT = 16
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cond,
  output logic      expired
);

  localparam int unsigned CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LIMIT = CW'(COUNT);

  if (COUNT < 1) begin : g_bad_count
    $error("qualification count must be at least one");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // Counts uninterrupted cycles of cond and restarts from zero whenever it drops.
  assign cnt_d   = !cond ? '0 : (cnt_q == LIMIT) ? cnt_q : cnt_q + 1'b1;
  assign expired = cond && (cnt_q == LIMIT);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  a_timer_restart: assert property (@(posedge clk) disable iff (!rst_n)
    !cond |=> cnt_q == '0)
    else $error("qualification counter did not restart");

endmodule : cpf_qual_timer

// ---- cpf_cell_model.sv ----
`timescale 1ns/10ps
module cpf_cell_model #(
  parameter int OCUR_MV  = 100,
  parameter int SHORT_MV = 1500,
  parameter int ZERO_MV  = 1500
) (
  input  wire cpf_pkg::cpf_drive_t drive,
  input  var  int                  cell_mv,
  input  wire logic                ext_on,
  input  var  int                  ext_mv,
  input  var  int                  chg_mv,
  output cpf_pkg::cpf_flags_t      flags
);
  int term_mv;

  // A released terminal follows the pull-up to the cell, else sits at ground.
  assign term_mv = ext_on ? ext_mv : (drive.pullup_en ? cell_mv : 0);

  // Comparator flags worked out from the cell and terminal voltages in mV.
  always_comb begin
    flags.cell_above_overcharge_detect    = cell_mv > 4300;
    flags.cell_below_overcharge_release   = cell_mv < 4100;
    flags.cell_below_overdischarge_detect = cell_mv < 2400;
    flags.cell_at_overdischarge_release   = cell_mv >= 3000;
    flags.term_above_diode_drop           = term_mv >= 700;
    flags.term_at_overcurrent             = term_mv >= OCUR_MV;
    flags.term_at_load_short              = term_mv >= SHORT_MV;
    flags.term_below_charger_detect       = term_mv < -120;
    flags.term_above_powerdown            = term_mv > 1500;
    flags.supply_term_diff_wake           = (cell_mv - term_mv) >= 1300;
    flags.charger_at_zero_volt_start      = chg_mv >= ZERO_MV;
  end
endmodule : cpf_cell_model

// ---- test_cpf_protect_fsm.sv ----
`timescale 1ns/10ps
module test_cpf_protect_fsm;
  localparam int OV = 16;
  localparam int OD = 8;
  localparam int OC = 4;
  localparam int SH = 2;

  logic                clk;
  logic                rst_n;
  cpf_pkg::cpf_flags_t flags_i;
  cpf_pkg::cpf_drive_t drive_q;
  cpf_pkg::cpf_state_t state_q;
  int                  cell_mv;
  logic                ext_on;
  int                  ext_mv;
  int                  chg_mv;
  int                  fails;
  int                  num_checks;
  int                  n;

  // Short counts keep the run brief; expectations derive from them.
  cpf_protect_fsm #(.OVCHG_CYCLES(OV), .ODSG_CYCLES(OD), .OCUR_CYCLES(OC), .SHORT_CYCLES(SH)) uut (
    .clk(clk), .rst_n(rst_n), .flags_i(flags_i), .drive_q(drive_q), .state_q(state_q));

  cpf_cell_model #(.OCUR_MV(1000)) model (
    .drive(drive_q), .cell_mv(cell_mv), .ext_on(ext_on), .ext_mv(ext_mv), .chg_mv(chg_mv), .flags(flags_i));

  // The clock toggles every half period.
  always #5 clk = ~clk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp_state(input cpf_pkg::cpf_state_t exp);
    num_checks++;
    if (state_q !== exp) begin
      fails++;
      $display("unexpected at %0t: state %0h, wanted %0h", $time, state_q, exp);
    end
  endtask : cmp_state

  task automatic cmp_drive(input logic [5:0] exp);
    num_checks++;
    if (drive_q !== exp) begin
      fails++;
      $display("unexpected at %0t: drive %0h, wanted %0h", $time, drive_q, exp);
    end
  endtask : cmp_drive

  task automatic cmp_n(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      fails++;
      $display("unexpected at %0t: %0d edges, wanted %0d", $time, got, exp);
    end
  endtask : cmp_n

  // Inputs change at the falling edge only.
  task automatic set(input int c, input logic e, input int t, input int z);
    @(negedge clk);
    cell_mv = c;
    ext_on  = e;
    ext_mv  = t;
    chg_mv  = z;
  endtask : set

  task automatic wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : wt

  // Counts rising edges until the state is reached, bounded by lim.
  task automatic go(input cpf_pkg::cpf_state_t exp, input int lim, output int k);
    k = 0;
    while (state_q !== exp && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    cmp_state(exp);
  endtask : go

  // The watchdog cuts a hang short well past the expected run time.
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end

  // Main sequence: each step drives the cell model and checks the outcome.
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cell_mv = 3600;
    ext_on = 1'b0;
    ext_mv = 0;
    chg_mv = 0;
    fails = 0;
    num_checks = 0;
    wt(4);
    @(negedge clk);
    rst_n = 1'b1;
    cmp_state(cpf_pkg::ST_NORMAL);
    cmp_drive(6'h30);
    set(4400, 1'b0, 0, 0);
    wt(OV - 2);
    set(3600, 1'b0, 0, 0);
    wt(3);
    cmp_state(cpf_pkg::ST_NORMAL);
    set(4400, 1'b0, 0, 0);
    go(cpf_pkg::ST_OVCHG, OV + 10, n);
    cmp_n(n, OV + 2);
    cmp_drive(6'h10);
    set(4400, 1'b1, 1200, 0);
    wt(OC + 6);
    cmp_state(cpf_pkg::ST_OVCHG);
    set(4400, 1'b0, 0, 0);
    wt(4);
    cmp_state(cpf_pkg::ST_OVCHG);
    set(4200, 1'b0, 0, 0);
    go(cpf_pkg::ST_NORMAL, 10, n);
    cmp_n(n, 2);
    set(4400, 1'b0, 0, 0);
    go(cpf_pkg::ST_OVCHG, OV + 10, n);
    // A diode-drop rise that stays under the overcurrent level must not release.
    set(4200, 1'b1, 800, 0);
    wt(6);
    cmp_state(cpf_pkg::ST_OVCHG);
    set(4000, 1'b0, 0, 0);
    go(cpf_pkg::ST_NORMAL, 10, n);
    cmp_n(n, 2);
    set(4400, 1'b0, 0, 0);
    go(cpf_pkg::ST_OVCHG, OV + 10, n);
    set(4400, 1'b1, 2000, 0);
    go(cpf_pkg::ST_SHORT, 10, n);
    cmp_n(n, SH + 2);
    set(3600, 1'b0, 0, 0);
    go(cpf_pkg::ST_NORMAL, 10, n);
    set(3600, 1'b1, 1200, 0);
    go(cpf_pkg::ST_OCUR, OC + 10, n);
    cmp_n(n, OC + 2);
    cmp_drive(6'h24);
    set(3600, 1'b0, 0, 0);
    go(cpf_pkg::ST_NORMAL, 10, n);
    set(3600, 1'b1, 2000, 0);
    go(cpf_pkg::ST_SHORT, 10, n);
    cmp_n(n, SH + 2);
    cmp_drive(6'h24);
    set(3600, 1'b0, 0, 0);
    go(cpf_pkg::ST_NORMAL, 10, n);
    set(3600, 1'b1, 1200, 0);
    go(cpf_pkg::ST_OCUR, OC + 10, n);
    set(2300, 1'b1, 1200, 0);
    go(cpf_pkg::ST_PWRDN, OD + 10, n);
    cmp_n(n, OD + 2);
    set(2300, 1'b1, -1000, 0);
    go(cpf_pkg::ST_ODSG, 10, n);
    cmp_n(n, 2);
    cmp_drive(6'h28);
    wt(OV + 5);
    cmp_state(cpf_pkg::ST_ODSG);
    set(2600, 1'b1, -1000, 0);
    go(cpf_pkg::ST_ABNCHG, OV + 10, n);
    cmp_n(n, OV + 2);
    cmp_drive(6'h10);
    set(2600, 1'b0, 0, 0);
    go(cpf_pkg::ST_NORMAL, 10, n);
    cmp_n(n, 2);
    set(2300, 1'b0, 0, 0);
    go(cpf_pkg::ST_ODSG, OD + 10, n);
    cmp_n(n, OD + 2);
    cmp_drive(6'h28);
    go(cpf_pkg::ST_PWRDN, 5, n);
    cmp_drive(6'h2A);
    set(2300, 1'b0, 0, 2000);
    go(cpf_pkg::ST_ZERO, 10, n);
    cmp_n(n, 2);
    cmp_drive(6'h01);
    set(3100, 1'b0, 0, 0);
    go(cpf_pkg::ST_NORMAL, 10, n);
    cmp_n(n, 2);
    set(2300, 1'b1, -1000, 0);
    go(cpf_pkg::ST_ODSG, OD + 10, n);
    cmp_n(n, OD + 2);
    set(3100, 1'b1, -1000, 0);
    go(cpf_pkg::ST_NORMAL, 10, n);
    cmp_n(n, 2);
    cmp_drive(6'h30);
    go(cpf_pkg::ST_ABNCHG, OV + 10, n);
    set(4400, 1'b0, 0, 0);
    go(cpf_pkg::ST_NORMAL, 10, n);
    go(cpf_pkg::ST_OVCHG, OV + 10, n);
    @(negedge clk);
    rst_n = 1'b0;
    wt(1);
    cmp_state(cpf_pkg::ST_NORMAL);
    cmp_drive(6'h30);
    set(3600, 1'b0, 0, 0);
    rst_n = 1'b1;
    wt(OV + 5);
    cmp_state(cpf_pkg::ST_NORMAL);
    report_and_stop();
  end
endmodule : test_cpf_protect_fsm
